// [pkg/heat_supervision_pkg.sv]
package heat_supervision_pkg;

	// Data widths shared by the block and its helpers.
	localparam int CUR_W  = 16;
	localparam int CAP_W  = 16;
	localparam int TIME_W = 24;
	localparam int CNT_W  = 16;

	// Current scaling: nominal current in per-unit counts.
	localparam logic [CUR_W-1:0] NOMINAL_CUR      = 16'h0400;
	// Light-load limit is 1 % of nominal, taken as nominal / 100.
	localparam int               LIGHT_LOAD_PCT   = 1;
	localparam int               PCT_FULL         = 100;
	// High overload above this multiple of nominal.
	localparam int               HIGH_OVL_MULT    = 2;

	// Thermal capacity full scale, 100 % theta, in capacity counts.
	localparam logic [CAP_W-1:0] CAP_FULL         = 16'h03e8;

	// Unity factor used when a setting is invalid, in 8.8 fixed point.
	localparam logic [15:0]      UNITY_FACTOR     = 16'h0100;

	// Blocking lead time needed before the operate delay expires.
	localparam int               BLOCK_LEAD_US    = 5000;
	localparam int               CLK_PERIOD_NS    = 20;
	localparam int               BLOCK_LEAD_CYC   = (BLOCK_LEAD_US * 1000) / CLK_PERIOD_NS;

	// Reset values.
	localparam logic [CNT_W-1:0]  CNT_RESET       = 16'h0000;
	localparam logic [TIME_W-1:0] TIME_RESET      = 24'h000000;

	// Operating condition reported to software.
	typedef enum logic [2:0] {
		COND_NORMAL,
		COND_ALARM1,
		COND_ALARM2,
		COND_INHIBIT,
		COND_TRIP,
		COND_BLOCKED
	} condition_type;

	// Thermal load classification.
	typedef enum logic [1:0] {
		LOAD_LIGHT,
		LOAD_NORMAL,
		LOAD_OVERLOADING,
		LOAD_HIGH_OVERLOAD
	} load_state_type;

	// Three phase true-RMS currents.
	typedef struct packed {
		logic [CUR_W-1:0] phase_a;
		logic [CUR_W-1:0] phase_b;
		logic [CUR_W-1:0] phase_c;
	} phase_currents_type;

	// Stage thresholds with individual enables.
	typedef struct packed {
		logic             alarm1_en;
		logic             alarm2_en;
		logic             inhibit_en;
		logic             trip_en;
		logic [CAP_W-1:0] alarm1_lvl;
		logic [CAP_W-1:0] alarm2_lvl;
		logic [CAP_W-1:0] inhibit_lvl;
		logic [CAP_W-1:0] trip_lvl;
	} thresholds_type;

	// Stage outputs.
	typedef struct packed {
		logic alarm1;
		logic alarm2;
		logic inhibit;
		logic trip;
	} stage_outputs_type;

	// Setting fault indications.
	typedef struct packed {
		logic service_factor_fault;
		logic ambient_fault;
		logic nominal_calc_fault;
		logic ambient_k_inconsistent;
	} setting_alarms_type;

	// Activation counters.
	typedef struct packed {
		logic [CNT_W-1:0] alarm1;
		logic [CNT_W-1:0] alarm2;
		logic [CNT_W-1:0] inhibit;
		logic [CNT_W-1:0] trip;
		logic [CNT_W-1:0] trip_blocked;
	} counters_type;

	// Cooling release times per threshold.
	typedef struct packed {
		logic [TIME_W-1:0] trip;
		logic [TIME_W-1:0] alarm1;
		logic [TIME_W-1:0] alarm2;
		logic [TIME_W-1:0] inhibit;
	} release_times_type;

endpackage : heat_supervision_pkg

// [design/activation_counter.sv]
`timescale 1ns/10ps

// Counts rising edges of one activation level; clearable and saturating.
module activation_counter #(
	parameter int WIDTH = 16
) (
	// Clock and reset.
	input  wire logic             i_mclk,
	input  wire logic             i_reset,
	// Event and clear.
	input  wire logic             i_level,
	input  wire logic             i_clear,
	// Count.
	output logic      [WIDTH-1:0] o_count
);

	logic             level_ff;
	logic [WIDTH-1:0] count_ff;

	// Remembers the previous level to find the rising edge.
	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			level_ff <= 1'b0;
		end else begin
			level_ff <= i_level;
		end
	end

	// An edge in the clear cycle still counts, so no activation is lost.
	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			count_ff <= '0;
		end else if (i_level && !level_ff) begin
			count_ff <= i_clear ? WIDTH'(1) : ((&count_ff) ? count_ff : count_ff + WIDTH'(1));
		end else if (i_clear) begin
			count_ff <= '0;
		end
	end

	assign o_count = count_ff;

endmodule : activation_counter

// [design/release_timer.sv]
`timescale 1ns/10ps

// Estimates cooling time for capacity to fall below a threshold.
module release_timer #(
	parameter int CAP_W  = 16,
	parameter int TIME_W = 24
) (
	// Clock and reset.
	input  wire logic              i_mclk,
	input  wire logic              i_reset,
	// Capacity, threshold and cooling rate in capacity counts per time unit.
	input  wire logic [CAP_W-1:0]  i_capacity,
	input  wire logic [CAP_W-1:0]  i_threshold,
	input  wire logic [CAP_W-1:0]  i_cool_rate,
	// Time to release.
	output logic      [TIME_W-1:0] o_time
);

	logic [TIME_W-1:0] time_ff;
	logic [CAP_W-1:0]  excess;

	// Capacity above the threshold that must still drain away.
	assign excess = (i_capacity > i_threshold) ? (i_capacity - i_threshold) : '0;

	// Linear cooling estimate; zero rate with capacity above the threshold yields the largest time.
	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			time_ff <= '0;
		end else if (excess == '0) begin
			time_ff <= '0;
		end else if (i_cool_rate == '0) begin
			time_ff <= '1;
		end else begin
			// Rounding up is done at the time width, so a large excess plus rate cannot wrap.
			time_ff <= (TIME_W'(excess) + TIME_W'(i_cool_rate) - TIME_W'(1)) / TIME_W'(i_cool_rate);
		end
	end

	assign o_time = time_ff;

endmodule : release_timer

// [design/thermal_overload_block_status.sv]
`timescale 1ns/10ps

module thermal_overload_block_status #(
	parameter int OPERATE_DELAY_W = 32
) (
	// Clock and reset.
	input  wire logic                                     i_mclk,
	input  wire logic                                     i_reset,
	// Program cycle strobe and blocking matrix input.
	input  wire logic                                     i_cycle_start,
	input  wire logic                                     i_block,
	// Measurements and thermal image values.
	input  wire heat_supervision_pkg::phase_currents_type i_currents,
	input  wire logic [heat_supervision_pkg::CAP_W-1:0]   i_capacity,
	input  wire logic [heat_supervision_pkg::CAP_W-1:0]   i_capacity_est,
	input  wire logic [heat_supervision_pkg::CAP_W-1:0]   i_cool_rate,
	input  wire logic [heat_supervision_pkg::CUR_W-1:0]   i_pickup_cur,
	// Settings.
	input  wire heat_supervision_pkg::thresholds_type     i_thresholds,
	input  wire logic [OPERATE_DELAY_W-1:0]               i_operate_delay,
	input  wire logic [15:0]                              i_service_factor,
	input  wire logic                                     i_service_factor_valid,
	input  wire logic [15:0]                              i_ambient_factor,
	input  wire logic                                     i_ambient_valid,
	input  wire logic [15:0]                              i_nominal_factor,
	input  wire logic                                     i_nominal_valid,
	input  wire logic                                     i_ambient_k_consistent,
	input  wire logic                                     i_counter_clear,
	// Stage and status outputs.
	output heat_supervision_pkg::stage_outputs_type       o_stages,
	output logic                                          o_start,
	output logic                                          o_blocked,
	output logic                                          o_releasing,
	output heat_supervision_pkg::condition_type           o_condition,
	output heat_supervision_pkg::load_state_type          o_load_state,
	output logic [heat_supervision_pkg::CUR_W-1:0]        o_active_current,
	output logic                                          o_trip_expected,
	// Setting alarms and applied factors.
	output heat_supervision_pkg::setting_alarms_type      o_setting_alarms,
	output logic [15:0]                                   o_service_factor_used,
	output logic [15:0]                                   o_ambient_factor_used,
	output logic [15:0]                                   o_nominal_factor_used,
	// Timing status and counters.
	output heat_supervision_pkg::release_times_type       o_release_times,
	output heat_supervision_pkg::counters_type            o_counters
);

	// Largest of three values.
	function automatic logic [heat_supervision_pkg::CUR_W-1:0] max3(
		input logic [heat_supervision_pkg::CUR_W-1:0] a,
		input logic [heat_supervision_pkg::CUR_W-1:0] b,
		input logic [heat_supervision_pkg::CUR_W-1:0] c
	);
		logic [heat_supervision_pkg::CUR_W-1:0] m;
		m = (a > b) ? a : b;
		return (m > c) ? m : c;
	endfunction : max3

	// Threshold comparison gated by the stage enable.
	function automatic logic stage_hit(
		input logic                                   en,
		input logic [heat_supervision_pkg::CAP_W-1:0] cap,
		input logic [heat_supervision_pkg::CAP_W-1:0] lvl
	);
		return en && (cap >= lvl);
	endfunction : stage_hit

	localparam logic [heat_supervision_pkg::CUR_W-1:0] LIGHT_LIMIT =
		heat_supervision_pkg::CUR_W'((32'(heat_supervision_pkg::NOMINAL_CUR) *
		heat_supervision_pkg::LIGHT_LOAD_PCT) / heat_supervision_pkg::PCT_FULL);
	localparam logic [heat_supervision_pkg::CUR_W:0] HIGH_LIMIT =
		(heat_supervision_pkg::CUR_W+1)'(32'(heat_supervision_pkg::NOMINAL_CUR) *
		heat_supervision_pkg::HIGH_OVL_MULT);

	logic                                     block_ff;
	logic                                     start_ff;
	logic                                     blocked_ff;
	logic                                     releasing_ff;
	logic [OPERATE_DELAY_W-1:0]               op_timer_ff;
	logic                                     trip_event_ff;
	logic                                     trip_blocked_ff;
	heat_supervision_pkg::stage_outputs_type  stages_ff;
	heat_supervision_pkg::condition_type      condition_ff;
	heat_supervision_pkg::load_state_type     load_ff;
	logic [heat_supervision_pkg::CUR_W-1:0]   active_cur_ff;
	logic                                     trip_expected_ff;
	heat_supervision_pkg::setting_alarms_type alarms_ff;
	logic [15:0]                              sf_used_ff;
	logic [15:0]                              amb_used_ff;
	logic [15:0]                              nom_used_ff;
	logic                                     pickup;
	logic                                     trip_raw;
	logic                                     trip_cond;
	logic [OPERATE_DELAY_W-1:0]               blk_timer_ff;
	logic                                     trip_held;

	// Blocking is taken once per program cycle and held until the next one.
	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			block_ff <= 1'b0;
		end else if (i_cycle_start) begin
			block_ff <= i_block;
		end
	end

	// Pick-up is the trip threshold being reached by the thermal image.
	assign pickup    = stage_hit(i_thresholds.trip_en, i_capacity, i_thresholds.trip_lvl);
	assign trip_raw  = pickup && (op_timer_ff >= i_operate_delay);
	assign trip_cond = trip_raw && !block_ff;
	assign trip_held = pickup && block_ff && (blk_timer_ff >= i_operate_delay);

	// Start, blocked and release decisions on pick-up.
	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			start_ff     <= 1'b0;
			blocked_ff   <= 1'b0;
			releasing_ff <= 1'b0;
		end else if (pickup && !block_ff) begin
			start_ff     <= 1'b1;
			blocked_ff   <= 1'b0;
			releasing_ff <= 1'b0;
		end else if (pickup && block_ff) begin
			start_ff     <= 1'b0;
			blocked_ff   <= 1'b1;
			releasing_ff <= start_ff;
		end else begin
			start_ff     <= 1'b0;
			blocked_ff   <= 1'b0;
			releasing_ff <= start_ff;
		end
	end

	// Operate delay timer runs only while started; blocking holds it at zero.
	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			op_timer_ff <= '0;
		end else if (pickup && !block_ff) begin
			if (op_timer_ff != '1) begin
				op_timer_ff <= op_timer_ff + OPERATE_DELAY_W'(1);
			end
		end else begin
			op_timer_ff <= '0;
		end
	end

	// Shadow of the operate delay under blocking; it only tells when a held-back trip would have fired.
	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			blk_timer_ff <= '0;
		end else if (pickup && block_ff) begin
			if (blk_timer_ff != '1) begin
				blk_timer_ff <= blk_timer_ff + OPERATE_DELAY_W'(1);
			end
		end else begin
			blk_timer_ff <= '0;
		end
	end

	// Stage outputs; trip is suppressed while blocked.
	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			stages_ff       <= '0;
			trip_event_ff   <= 1'b0;
			trip_blocked_ff <= 1'b0;
		end else begin
			stages_ff.alarm1  <= stage_hit(i_thresholds.alarm1_en, i_capacity, i_thresholds.alarm1_lvl);
			stages_ff.alarm2  <= stage_hit(i_thresholds.alarm2_en, i_capacity, i_thresholds.alarm2_lvl);
			stages_ff.inhibit <= stage_hit(i_thresholds.inhibit_en, i_capacity, i_thresholds.inhibit_lvl);
			stages_ff.trip    <= trip_cond;
			trip_event_ff     <= trip_cond;
			trip_blocked_ff   <= trip_held;
		end
	end

	// Condition code with the most severe state shown first.
	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			condition_ff <= heat_supervision_pkg::COND_NORMAL;
		end else if (pickup && block_ff) begin
			condition_ff <= heat_supervision_pkg::COND_BLOCKED;
		end else if (trip_cond) begin
			condition_ff <= heat_supervision_pkg::COND_TRIP;
		end else if (stage_hit(i_thresholds.inhibit_en, i_capacity, i_thresholds.inhibit_lvl)) begin
			condition_ff <= heat_supervision_pkg::COND_INHIBIT;
		end else if (stage_hit(i_thresholds.alarm2_en, i_capacity, i_thresholds.alarm2_lvl)) begin
			condition_ff <= heat_supervision_pkg::COND_ALARM2;
		end else if (stage_hit(i_thresholds.alarm1_en, i_capacity, i_thresholds.alarm1_lvl)) begin
			condition_ff <= heat_supervision_pkg::COND_ALARM1;
		end else begin
			condition_ff <= heat_supervision_pkg::COND_NORMAL;
		end
	end

	// Active current and load classification from the same sample.
	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			active_cur_ff <= '0;
			load_ff       <= heat_supervision_pkg::LOAD_LIGHT;
		end else begin
			active_cur_ff <= max3(i_currents.phase_a, i_currents.phase_b, i_currents.phase_c);
			if (max3(i_currents.phase_a, i_currents.phase_b, i_currents.phase_c) < LIGHT_LIMIT) begin
				load_ff <= heat_supervision_pkg::LOAD_LIGHT;
			end else if ({1'b0, max3(i_currents.phase_a, i_currents.phase_b, i_currents.phase_c)} > HIGH_LIMIT) begin
				load_ff <= heat_supervision_pkg::LOAD_HIGH_OVERLOAD;
			end else if (max3(i_currents.phase_a, i_currents.phase_b, i_currents.phase_c) > i_pickup_cur) begin
				load_ff <= heat_supervision_pkg::LOAD_OVERLOADING;
			end else begin
				load_ff <= heat_supervision_pkg::LOAD_NORMAL;
			end
		end
	end

	// Trip expectation from the capacity estimate with present current.
	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			trip_expected_ff <= 1'b0;
		end else begin
			trip_expected_ff <= i_capacity_est >= i_thresholds.trip_lvl;
		end
	end

	// Setting alarms follow the fault; unity substitutes bad factors.
	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			alarms_ff   <= '0;
			sf_used_ff  <= heat_supervision_pkg::UNITY_FACTOR;
			amb_used_ff <= heat_supervision_pkg::UNITY_FACTOR;
			nom_used_ff <= heat_supervision_pkg::UNITY_FACTOR;
		end else begin
			alarms_ff.service_factor_fault   <= !i_service_factor_valid;
			alarms_ff.ambient_fault          <= !i_ambient_valid;
			alarms_ff.nominal_calc_fault     <= !i_nominal_valid;
			alarms_ff.ambient_k_inconsistent <= !i_ambient_k_consistent;
			sf_used_ff  <= i_service_factor_valid ? i_service_factor : heat_supervision_pkg::UNITY_FACTOR;
			amb_used_ff <= i_ambient_valid ? i_ambient_factor : heat_supervision_pkg::UNITY_FACTOR;
			nom_used_ff <= i_nominal_valid ? i_nominal_factor : heat_supervision_pkg::UNITY_FACTOR;
		end
	end

	// Cooling release times per threshold.
	release_timer #(.CAP_W(heat_supervision_pkg::CAP_W), .TIME_W(heat_supervision_pkg::TIME_W)) u_rel_trip (
		.i_mclk      (i_mclk),
		.i_reset     (i_reset),
		.i_capacity  (i_capacity),
		.i_threshold (i_thresholds.trip_lvl),
		.i_cool_rate (i_cool_rate),
		.o_time      (o_release_times.trip)
	);
	release_timer #(.CAP_W(heat_supervision_pkg::CAP_W), .TIME_W(heat_supervision_pkg::TIME_W)) u_rel_a1 (
		.i_mclk      (i_mclk),
		.i_reset     (i_reset),
		.i_capacity  (i_capacity),
		.i_threshold (i_thresholds.alarm1_lvl),
		.i_cool_rate (i_cool_rate),
		.o_time      (o_release_times.alarm1)
	);
	release_timer #(.CAP_W(heat_supervision_pkg::CAP_W), .TIME_W(heat_supervision_pkg::TIME_W)) u_rel_a2 (
		.i_mclk      (i_mclk),
		.i_reset     (i_reset),
		.i_capacity  (i_capacity),
		.i_threshold (i_thresholds.alarm2_lvl),
		.i_cool_rate (i_cool_rate),
		.o_time      (o_release_times.alarm2)
	);
	release_timer #(.CAP_W(heat_supervision_pkg::CAP_W), .TIME_W(heat_supervision_pkg::TIME_W)) u_rel_inh (
		.i_mclk      (i_mclk),
		.i_reset     (i_reset),
		.i_capacity  (i_capacity),
		.i_threshold (i_thresholds.inhibit_lvl),
		.i_cool_rate (i_cool_rate),
		.o_time      (o_release_times.inhibit)
	);

	// Edge counters for each activation; a shared clear empties them all, and one with an edge in that cycle restarts at one.
	activation_counter #(.WIDTH(heat_supervision_pkg::CNT_W)) u_cnt_a1 (
		.i_mclk  (i_mclk),
		.i_reset (i_reset),
		.i_level (stages_ff.alarm1),
		.i_clear (i_counter_clear),
		.o_count (o_counters.alarm1)
	);
	activation_counter #(.WIDTH(heat_supervision_pkg::CNT_W)) u_cnt_a2 (
		.i_mclk  (i_mclk),
		.i_reset (i_reset),
		.i_level (stages_ff.alarm2),
		.i_clear (i_counter_clear),
		.o_count (o_counters.alarm2)
	);
	activation_counter #(.WIDTH(heat_supervision_pkg::CNT_W)) u_cnt_inh (
		.i_mclk  (i_mclk),
		.i_reset (i_reset),
		.i_level (stages_ff.inhibit),
		.i_clear (i_counter_clear),
		.o_count (o_counters.inhibit)
	);
	activation_counter #(.WIDTH(heat_supervision_pkg::CNT_W)) u_cnt_trip (
		.i_mclk  (i_mclk),
		.i_reset (i_reset),
		.i_level (trip_event_ff),
		.i_clear (i_counter_clear),
		.o_count (o_counters.trip)
	);
	activation_counter #(.WIDTH(heat_supervision_pkg::CNT_W)) u_cnt_blk (
		.i_mclk  (i_mclk),
		.i_reset (i_reset),
		.i_level (trip_blocked_ff),
		.i_clear (i_counter_clear),
		.o_count (o_counters.trip_blocked)
	);

	// Register-driven outputs.
	assign o_stages              = stages_ff;
	assign o_start               = start_ff;
	assign o_blocked             = blocked_ff;
	assign o_releasing           = releasing_ff;
	assign o_condition           = condition_ff;
	assign o_load_state          = load_ff;
	assign o_active_current      = active_cur_ff;
	assign o_trip_expected       = trip_expected_ff;
	assign o_setting_alarms      = alarms_ff;
	assign o_service_factor_used = sf_used_ff;
	assign o_ambient_factor_used = amb_used_ff;
	assign o_nominal_factor_used = nom_used_ff;

endmodule : thermal_overload_block_status

// [verif/block_matrix_model.sv]
`timescale 1ns/10ps
// Stand-in for the blocking matrix: passes the wanted blocking level to the relay, promptly or two clocks late.
module block_matrix_model (
	input  wire logic i_mclk,
	input  wire logic i_want_block,
	input  wire logic i_slow,
	output logic      o_block
);
	logic [1:0] lag_ff = 2'h0;
	// Changes just after a rising edge; the slow path changes the level two clocks later than the fast path.
	always @(posedge i_mclk) begin
		lag_ff <= {lag_ff[0], i_want_block};
		o_block <= i_slow ? lag_ff[1] : i_want_block;
	end
	// The wire starts unblocked.
	initial o_block = 1'b0;
endmodule : block_matrix_model

// [verif/heat_supervision_asserts.sv]
`timescale 1ns/10ps
// Watches the thermal supervision ports.
module heat_supervision_asserts (
	input wire logic                                     i_mclk,
	input wire logic                                     i_reset,
	input wire logic                                     i_cycle_start,
	input wire logic                                     i_block,
	input wire heat_supervision_pkg::phase_currents_type i_currents,
	input wire logic [15:0]                              i_capacity,
	input wire heat_supervision_pkg::thresholds_type     i_thresholds,
	input wire logic                                     i_counter_clear,
	input wire heat_supervision_pkg::stage_outputs_type  o_stages,
	input wire logic                                     o_start,
	input wire logic                                     o_blocked,
	input wire heat_supervision_pkg::condition_type      o_condition,
	input wire heat_supervision_pkg::load_state_type     o_load_state,
	input wire logic [15:0]                              o_active_current,
	input wire heat_supervision_pkg::counters_type       o_counters
);
	logic [15:0] cur_max, ab;
	logic        trip_hit, a1_hit;
	// Largest phase and threshold hits.
	assign ab       = (i_currents.phase_a > i_currents.phase_b) ? i_currents.phase_a : i_currents.phase_b;
	assign cur_max  = (i_currents.phase_c > ab) ? i_currents.phase_c : ab;
	assign trip_hit = i_thresholds.trip_en && (i_capacity >= i_thresholds.trip_lvl);
	assign a1_hit   = i_thresholds.alarm1_en && (i_capacity >= i_thresholds.alarm1_lvl);
	default clocking @(posedge i_mclk); endclocking
	default disable iff (i_reset);
	AST_ACTIVE_MAX: assert property (1'b1 |=> o_active_current == $past(cur_max))
		else $error("active current wrong");
	AST_HIGH: assert property (cur_max > 16'h0800 |=> o_load_state == heat_supervision_pkg::LOAD_HIGH_OVERLOAD)
		else $error("high overload missed");
	AST_ALARM1: assert property (1'b1 |=> o_stages.alarm1 == $past(a1_hit))
		else $error("alarm 1 stage wrong");
	AST_START: assert property (
		!trip_hit ##1 i_cycle_start && !i_block && trip_hit ##1 trip_hit |=> o_start && !o_blocked)
		else $error("start missed");
	AST_BLOCKED: assert property (
		i_cycle_start && i_block && trip_hit ##1 trip_hit |=> o_blocked && !o_start
		&& o_condition == heat_supervision_pkg::COND_BLOCKED)
		else $error("blocked missed");
	AST_BLOCK_HOLD: assert property (
		$past(trip_hit) && $past(trip_hit, 2) && !$past(i_cycle_start, 2) |-> $stable(o_blocked))
		else $error("blocking taken off cycle");
	AST_CNT_RISE: assert property (
		$rose(o_stages.alarm1) && !i_counter_clear && o_counters.alarm1 != 16'hffff
		|=> o_counters.alarm1 == $past(o_counters.alarm1) + 16'h0001)
		else $error("alarm 1 count wrong");
	AST_CLEAR: assert property (i_counter_clear && $stable(o_stages.alarm1) |=> o_counters.alarm1 == 16'h0000)
		else $error("clear failed");
	cover property (o_blocked);
	cover property ($rose(o_stages.trip));
	cover property (i_counter_clear);
endmodule : heat_supervision_asserts
bind thermal_overload_block_status heat_supervision_asserts heat_supervision_asserts_i (.*);

// [verif/tb.sv]
`timescale 1ns/10ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin fail_count++; \
	$display("mismatch at %0t got %h expected %h", $time, g, e); end end
// Self-checking bench for the thermal supervision block.
module tb;
	logic        i_mclk = 1'b0, i_reset = 1'b1, i_cycle_start = 1'b0, i_block, want_block = 1'b0, slow = 1'b1;
	logic        i_service_factor_valid = 1'b1, i_ambient_valid = 1'b1, i_nominal_valid = 1'b1;
	logic        i_ambient_k_consistent = 1'b1, i_counter_clear = 1'b0, o_start, o_blocked, o_releasing;
	logic        o_trip_expected;
	logic [47:0] i_currents = '0;
	logic [15:0] i_capacity = '0, i_capacity_est = '0, i_cool_rate = 16'h0030, i_pickup_cur = 16'h0600;
	logic [15:0] i_service_factor = '0, i_ambient_factor = '0, i_nominal_factor = '0, r16;
	logic [15:0] o_active_current, o_service_factor_used, o_ambient_factor_used, o_nominal_factor_used;
	logic [67:0] i_thresholds = {4'hf, 16'h0190, 16'h0258, 16'h0320, 16'h03e8};
	logic [31:0] i_operate_delay = 32'h5;
	logic [3:0]  o_stages, o_setting_alarms;
	logic [2:0]  o_condition;
	logic [1:0]  o_load_state;
	logic [95:0] o_release_times;
	logic [79:0] o_counters;
	logic [63:0] cor = {16'h0009, 16'h000a, 16'h0800, 16'h0801};
	logic [47:0] lvl = {16'h0190, 16'h0258, 16'h0320};
	int          fail_count = 0, comparisons = 0;
	thermal_overload_block_status thermal_overload_block_status_i (.*);
	block_matrix_model block_matrix_model_i (.i_mclk, .i_want_block(want_block), .i_slow(slow), .o_block(i_block));
	// 50 MHz clock.
	always #10 i_mclk = ~i_mclk;
	task automatic tick(int n);
		repeat (n) @(negedge i_mclk);
	endtask : tick
	// One program cycle: a sampling strobe, then three quiet clocks.
	task automatic prog(int n);
		repeat (n) begin
			i_cycle_start = 1'b1;
			tick(1);
			i_cycle_start = 1'b0;
			tick(3);
		end
	endtask : prog
	function automatic logic [15:0] max3(logic [47:0] c);
		logic [15:0] m;
		m = (c[47:32] > c[31:16]) ? c[47:32] : c[31:16];
		return (c[15:0] > m) ? c[15:0] : m;
	endfunction : max3
	// Light below 1 % of nominal, high above twice nominal.
	function automatic logic [1:0] exp_load(logic [15:0] x);
		if (x < 16'h000a) return 2'h0;
		if (x > 16'h0800) return 2'h3;
		return (x > i_pickup_cur) ? 2'h2 : 2'h1;
	endfunction : exp_load
	task automatic test_done;
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : test_done
	// Main sequence.
	initial begin
		void'($urandom(60));
		tick(3);
		i_reset = 1'b0;
		for (int k = 0; k < 40; k++) begin
			i_currents = {16'($urandom_range(0, 16'h0c00)), 16'($urandom_range(0, 16'h0c00)), 16'($urandom % 16'h0c00)};
			if (k < 4) i_currents = {16'h0000, cor[16*k +: 16], 16'h0002};
			tick(1);
			`CHK(o_active_current, max3(i_currents))
			`CHK(o_load_state, exp_load(max3(i_currents)))
		end
		$display("load test done");
		for (int k = 0; k < 5; k++) begin
			{i_service_factor_valid, i_ambient_valid, i_nominal_valid, i_ambient_k_consistent} = ~(4'h8 >> k);
			r16 = 16'($urandom);
			i_service_factor = r16;
			i_ambient_factor = ~r16;
			i_nominal_factor = r16 ^ 16'h0f0f;
			i_capacity_est = (k % 2 == 1) ? r16 : 16'h03e7;
			tick(1);
			`CHK(o_trip_expected, i_capacity_est >= 16'h03e8)
			`CHK(o_setting_alarms, 4'h8 >> k)
			`CHK(o_service_factor_used, (k == 0) ? 16'h0100 : r16)
			`CHK(o_ambient_factor_used, (k == 1) ? 16'h0100 : ~r16)
			`CHK(o_nominal_factor_used, (k == 2) ? 16'h0100 : r16 ^ 16'h0f0f)
		end
		$display("settings test done");
		for (int r = 1; r < 3; r++) begin
			for (int k = 0; k < 3; k++) begin
				i_capacity = lvl[32-16*k +: 16] - 16'h0001;
				tick(2);
				`CHK(o_stages, 4'(4'he << (3 - k)))
				i_capacity = lvl[32-16*k +: 16];
				tick(2);
				`CHK(o_stages, 4'(4'he << (2 - k)))
				`CHK(o_condition, 3'(k + 1))
				if (k == 2) `CHK(o_release_times, {24'h000000, 24'h000009, 24'h000005, 24'h000000})
			end
			i_capacity = '0;
			tick(2);
			`CHK({o_stages, o_condition}, 7'h00)
			`CHK(o_counters[79:32], {3{16'(r)}})
		end
		$display("stage test done");
		i_capacity = 16'h03e8;
		prog(1);
		`CHK(o_start, 1'b1)
		for (int n = 0; n < 20 && o_stages[0] !== 1'b1; n++) tick(1);
		tick(1);
		`CHK(o_condition, 3'h4)
		`CHK(o_counters[31:16], 16'h0001)
		i_capacity = '0;
		want_block = 1'b1;
		prog(2);
		i_capacity = 16'h03e8;
		prog(1);
		`CHK({o_blocked, o_start, o_condition}, 5'h15)
		tick(12);
		`CHK({o_counters[15:0], o_stages[0]}, 17'h00002)
		i_capacity = '0;
		want_block = 1'b0;
		i_operate_delay = 32'h3e8;
		prog(2);
		i_capacity = 16'h03e8;
		prog(1);
		`CHK(o_start, 1'b1)
		want_block = 1'b1;
		tick(4);
		i_cycle_start = 1'b1;
		tick(1);
		i_cycle_start = 1'b0;
		for (int n = 0; n < 6 && o_releasing !== 1'b1; n++) tick(1);
		`CHK({o_releasing, o_start}, 2'h2)
		$display("blocking test done");
		i_capacity = '0;
		tick(2);
		i_counter_clear = 1'b1;
		tick(1);
		i_counter_clear = 1'b0;
		`CHK(o_counters, 80'h0)
		$display("clear test done");
		test_done();
	end
	// Watchdog against a hung run.
	initial begin
		repeat (5000) @(posedge i_mclk);
		fail_count++;
		test_done();
	end
endmodule : tb
